// >>> rtl/phy_flag_if.sv
// Flag set and clear signals between the bank and the flag module
`timescale 1ns/1ns
interface phy_flag_if;
    logic [3:0] setFlags;
    logic [3:0] clearFlags;
    logic [3:0] flags;

    modport bank (output setFlags, output clearFlags, input flags);
    modport store (input setFlags, input clearFlags, output flags);
endinterface

// >>> rtl/phy_flag_store.sv
// Sticky write-one-to-clear event flags
`timescale 1ns/1ns
module phy_flag_store
    import phy_status_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst_n,
    // Flag traffic
    phy_flag_if.store  flagBus
);

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : gFlag
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    flagBus.flags[i] <= RST_FLAGS[i];
                else if (flagBus.setFlags[i])
                    flagBus.flags[i] <= 1'b1;
                else if (flagBus.clearFlags[i])
                    flagBus.flags[i] <= 1'b0;
            end
        end
    endgenerate

endmodule // phy_flag_store

// >>> rtl/phy_short_reset.sv
// Timer for short arbitrated bus reset
`timescale 1ns/1ns
module phy_short_reset
    import phy_status_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst_n,
    // Control
    input  wire logic  start,
    output logic       busy
);

    reset_state_t      state;
    logic [7:0]        count;
    wire               done = (count == 8'(SHORT_RESET_CYC - 1));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= RESET_IDLE;
            count <= 8'h00;
        end
        else
        begin
            case (state)
                RESET_IDLE:
                begin
                    count <= 8'h00;
                    if (start)
                        state <= RESET_ACTIVE;
                end
                RESET_ACTIVE:
                begin
                    count <= count + 8'h01;
                    if (done)
                        state <= RESET_IDLE;
                end
                default:
                    state <= RESET_IDLE;
            endcase
        end
    end

    assign busy = (state == RESET_ACTIVE);

endmodule // phy_short_reset

// >>> rtl/phy_status_bank.sv
// PHY status and control register bank behind classic Wishbone
// Behaviour
// - self-ID link bit is report AND power
// - link report sets on reset, holds otherwise
// - interface operational follows link power only
// - contender to self-ID bit 20, software set
// - jitter field reads zero
// - power class from pins at reset
// - watch enable makes resume raise port event
// - short reset request runs 1.3 us reset
// - config timeout flag set on tree timeout
// - watched flags with idle link wake link
// - config timeout only with legacy nodes
// - non-loop node timeout sets state flag, resets
// - cable drop flag on falling sense, resets 1
// - state timeout input also causes bus reset, one cycle later
// - port status change on an enabled port sets port event flag
`timescale 1ns/1ns
module phy_status_bank
    import phy_status_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // Link side
    input  wire logic                    link_power_status_in,
    input  wire logic                    link_request_in,
    output logic                         link_wake_out,
    output logic                         linkOperational,
    output logic                         linkRequestTaken,
    // Node configuration
    input  wire logic [2:0]              power_class_pins,
    input  wire logic                    cable_power_sense_in,
    // Arbitration and port events
    input  wire logic                    busResetIn,
    input  wire logic                    treeIdTimeout,
    input  wire logic                    legacyTopology,
    input  wire logic                    stateTimeout,
    input  wire logic [PORT_COUNT-1:0]   portStatusChange,
    input  wire logic [PORT_COUNT-1:0]   resumeStart,
    // Bus reset and self-ID
    output logic                         busResetOut,
    output logic                         shortResetActive,
    output logic [31:0]                  selfIdBits
);

    import phy_status_pkg::*;

    phy_flag_if flagBus();

    logic                    link_active_report;
    logic                    contender;
    logic [2:0]              powerClass;
    logic                    resume_watch_int_enable;
    logic                    short_reset_request;
    logic [PORT_COUNT-1:0]   port_int_enable;
    logic                    powerCaught;
    logic                    senseLast;
    logic                    timeoutReset;
    logic                    shortStartDone;

    wire                     config_timeout_flag   = flagBus.flags[FLG_CONFIG_TO];
    wire                     cable_power_drop_flag = flagBus.flags[FLG_CABLE_DROP];
    wire                     state_timeout_flag    = flagBus.flags[FLG_STATE_TO];
    wire                     port_event_flag       = flagBus.flags[FLG_PORT_EVENT];

    // Bus decode
    wire                     access      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire                     writeAccess = access & wb_we_i;
    wire                     hitControl  = (wb_adr_i == ADDR_CONTROL);
    wire                     hitFlags    = (wb_adr_i == ADDR_FLAGS);
    wire                     hitPorts    = (wb_adr_i == ADDR_PORT_ENABLE);
    wire                     hitSelfId   = (wb_adr_i == ADDR_SELF_ID);
    wire                     writeCtlLo  = writeAccess & hitControl & wb_sel_i[0];
    wire                     writeCtlHi  = writeAccess & hitControl & wb_sel_i[1];
    wire                     writeFlags  = writeAccess & hitFlags & wb_sel_i[0];
    wire                     writePorts  = writeAccess & hitPorts & wb_sel_i[0];

    wire                     linkActive  = link_power_status_in;
    wire                     senseFall   = senseLast & ~cable_power_sense_in;
    wire                     anyPortEvt  = |(portStatusChange & port_int_enable);
    wire                     anyResume   = resume_watch_int_enable & (|resumeStart);
    wire                     busReset    = busResetIn | busResetOut;

    // Read data views
    wire [31:0]              controlView = {22'h000000,
                                            short_reset_request,
                                            resume_watch_int_enable,
                                            powerClass,
                                            JITTER_VALUE,
                                            contender,
                                            link_active_report};
    wire [31:0]              flagView    = {28'h0000000, flagBus.flags};
    wire [31:0]              portView    = {{(32 - PORT_COUNT){1'b0}}, port_int_enable};

    wire [31:0]              readMux     = hitControl ? controlView :
                                           hitFlags   ? flagView :
                                           hitPorts   ? portView :
                                           hitSelfId  ? selfIdBits : 32'h00000000;

    // Event flags
    assign flagBus.setFlags[FLG_CONFIG_TO]  = treeIdTimeout & legacyTopology;
    assign flagBus.setFlags[FLG_CABLE_DROP] = senseFall;
    assign flagBus.setFlags[FLG_STATE_TO]   = stateTimeout;
    assign flagBus.setFlags[FLG_PORT_EVENT] = anyPortEvt | anyResume;
    assign flagBus.clearFlags               = writeFlags ? wb_dat_i[3:0] : 4'h0;

    phy_flag_store uFlags
    (
        .clock   (clock),
        .rst_n   (rst_n),
        .flagBus (flagBus.store)
    );

    phy_short_reset uShortReset
    (
        .clock (clock),
        .rst_n (rst_n),
        .start (short_reset_request & ~shortResetActive & ~shortStartDone),
        .busy  (shortResetActive)
    );

    // Wishbone answer
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= access;
            if (access)
                wb_dat_o <= readMux;
        end
    end

    // Control bits that bus reset leaves alone
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            link_active_report      <= RST_LINK_ACTIVE;
            contender               <= RST_CONTENDER;
            resume_watch_int_enable <= RST_WATCH_EN;
            port_int_enable         <= '0;
        end
        else
        begin
            if (writeCtlLo)
            begin
                link_active_report <= wb_dat_i[CTL_LINK_ACTIVE];
                contender          <= wb_dat_i[CTL_CONTENDER];
            end
            if (writeCtlHi)
                resume_watch_int_enable <= wb_dat_i[CTL_WATCH_EN];
            if (writePorts)
                port_int_enable <= wb_dat_i[PORT_COUNT-1:0];
        end
    end

    // Power class is caught from the pins in the first cycle after reset release
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            powerCaught <= 1'b0;
        else
            powerCaught <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!powerCaught)
            powerClass <= power_class_pins;
        else if (writeCtlLo)
            powerClass <= wb_dat_i[CTL_POWER_LO +: 3];
    end

    // Short reset request, cleared by any bus reset
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            short_reset_request <= RST_SHORT_RESET;
            shortStartDone      <= 1'b0;
        end
        else
        begin
            if (writeCtlHi & wb_dat_i[CTL_SHORT_RESET])
                short_reset_request <= 1'b1;
            else if (busReset)
                short_reset_request <= 1'b0;
            // Delayed busy: bus reset pulse only in the first timer cycle
            shortStartDone <= shortResetActive;
        end
    end

    // Sense edge, timeout reset and link wake
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            senseLast     <= 1'b1;
            timeoutReset  <= 1'b0;
            link_wake_out <= 1'b0;
        end
        else
        begin
            senseLast     <= cable_power_sense_in;
            timeoutReset  <= stateTimeout;
            link_wake_out <= resume_watch_int_enable & ~linkActive &
                             (config_timeout_flag | cable_power_drop_flag | state_timeout_flag);
        end
    end

    assign busResetOut      = timeoutReset | (shortResetActive & ~shortStartDone);
    assign linkOperational  = linkActive;
    assign linkRequestTaken = linkActive & link_request_in;

    // Self-ID packet fields
    always_comb
    begin
        selfIdBits                        = 32'h00000000;
        selfIdBits[SID_LINK_ACTIVE]       = link_active_report & link_power_status_in;
        selfIdBits[SID_CONTENDER]         = contender;
        selfIdBits[SID_POWER_LO +: 3]     = powerClass;
    end

endmodule // phy_status_bank

// >>> rtl/phy_status_pkg.sv
// Constants, register map and types for the PHY status and control bank
package phy_status_pkg;

    localparam int            PORT_COUNT        = 3;
    localparam int            CLOCK_MHZ         = 125;

    // Short arbitrated bus reset length
    localparam int            SHORT_RESET_NS    = 1300;
    localparam int            SHORT_RESET_CYC   = (SHORT_RESET_NS * CLOCK_MHZ + 999) / 1000;

    // Register byte addresses
    localparam logic [3:0]    ADDR_CONTROL      = 4'h0;
    localparam logic [3:0]    ADDR_FLAGS        = 4'h4;
    localparam logic [3:0]    ADDR_PORT_ENABLE  = 4'h8;
    localparam logic [3:0]    ADDR_SELF_ID      = 4'hC;

    // Control register fields
    localparam int            CTL_LINK_ACTIVE   = 0;
    localparam int            CTL_CONTENDER     = 1;
    localparam int            CTL_JITTER_LO     = 2;
    localparam int            CTL_POWER_LO      = 5;
    localparam int            CTL_WATCH_EN      = 8;
    localparam int            CTL_SHORT_RESET   = 9;

    // Flag register fields
    localparam int            FLG_CONFIG_TO     = 0;
    localparam int            FLG_CABLE_DROP    = 1;
    localparam int            FLG_STATE_TO      = 2;
    localparam int            FLG_PORT_EVENT    = 3;

    // Self-ID packet bit positions
    localparam int            SID_LINK_ACTIVE   = 9;
    localparam int            SID_CONTENDER     = 20;
    localparam int            SID_POWER_LO      = 21;

    // Reset values
    localparam logic          RST_LINK_ACTIVE   = 1'b1;
    localparam logic          RST_CONTENDER     = 1'b0;
    localparam logic          RST_WATCH_EN      = 1'b0;
    localparam logic          RST_SHORT_RESET   = 1'b0;
    localparam logic [3:0]    RST_FLAGS         = 4'h2;
    localparam logic [2:0]    JITTER_VALUE      = 3'h0;

    typedef enum logic [1:0]
    {
        RESET_IDLE   = 2'b00,
        RESET_ACTIVE = 2'b01
    } reset_state_t;

endpackage

// >>> verification/link_ctrl_model.sv
// Behavioural link controller on the far side of the link pins
`timescale 1ns/1ns
module link_ctrl_model
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Bench control and wake
    input  wire logic sleepCmd,
    input  wire logic linkWake,
    // Link pins
    output logic      linkPower,
    output logic      linkRequest
);
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            linkPower   <= 1'b1;
            linkRequest <= 1'b0;
        end
        else
        begin
            linkRequest <= 1'($urandom);
            // Asleep while commanded, a wake request powers it up on the next clock
            linkPower   <= linkWake || !sleepCmd;
        end
    end
endmodule // link_ctrl_model

// >>> verification/phy_status_bank_sva.sv
// Port checker for the PHY status and control bank
`timescale 1ns/1ns
module phy_status_bank_sva
    import phy_status_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Link and events
    input  wire logic        link_power_status_in,
    input  wire logic        link_request_in,
    input  wire logic        link_wake_out,
    input  wire logic        linkOperational,
    input  wire logic        linkRequestTaken,
    input  wire logic        stateTimeout,
    input  wire logic        busResetOut,
    input  wire logic        shortResetActive,
    input  wire logic [31:0] selfIdBits
);
    import phy_status_pkg::*;

    int runLen;

    always_ff @(posedge clock)
    begin
        if (!rst_n || !shortResetActive)
            runLen <= 0;
        else
            runLen <= runLen + 1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence wbTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackOnce;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    chk_ack_one_cycle: assert property (wbTaken |=> ackOnce)
        else $error("ack not a single cycle after request");
    chk_link_oper_follows: assert property (linkOperational == link_power_status_in
        && linkRequestTaken == (link_power_status_in && link_request_in)) else $error("link service wrong");
    chk_sid_link_bit: assert property (selfIdBits[9] |-> link_power_status_in)
        else $error("self-ID link bit without link power");
    chk_state_bus_reset: assert property (stateTimeout |=> busResetOut)
        else $error("state timeout gave no bus reset");
    chk_jitter_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_CONTROL
        |-> wb_dat_o[4:2] == 3'h0) else $error("jitter field not zero");
    chk_wake_link_idle: assert property (link_wake_out |-> !$past(link_power_status_in))
        else $error("wake while link active");
    chk_short_length: assert property ($fell(shortResetActive) |-> runLen == SHORT_RESET_CYC)
        else $error("short reset length wrong");
    chk_short_start: assert property ($rose(shortResetActive) |-> busResetOut)
        else $error("short reset without bus reset");
    chk_short_one_pulse: assert property (shortResetActive && $past(shortResetActive)
        && !$past(stateTimeout) |-> !busResetOut) else $error("short reset bus pulse too long");
endmodule // phy_status_bank_sva

bind phy_status_bank phy_status_bank_sva chk_u (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .link_power_status_in, .link_request_in, .link_wake_out, .linkOperational,
    .linkRequestTaken, .stateTimeout, .busResetOut, .shortResetActive, .selfIdBits);

// >>> verification/phy_status_bank_test.sv
// Self-checking bench for the PHY status and control bank
`timescale 1ns/1ns
module phy_status_bank_test;
    import phy_status_pkg::*;

    logic        clock = 0;
    logic        rst_n = 0;
    logic        wbReq = 0;
    logic        wbWe = 0;
    logic [3:0]  wbAdr = 0;
    logic [31:0] wbDatI = 0;
    logic [31:0] rd;
    logic [31:0] v;
    logic [2:0]  pins = 0;
    logic [10:0] ev = 0;
    logic        sleepCmd = 0;
    wire  [31:0] wbDatO;
    wire  [31:0] sid;
    wire         ack, power, req, wake, oper, taken, busOut, shortAct;
    int          errors = 0;
    int          total_checks = 0;
    int          p;
    int          n;

    phy_status_bank dut_u (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wbReq), .wb_stb_i(wbReq), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(ack),
        .link_power_status_in(power), .link_request_in(req), .link_wake_out(wake), .linkOperational(oper),
        .linkRequestTaken(taken), .power_class_pins(pins), .cable_power_sense_in(!ev[9]),
        .busResetIn(ev[2]), .treeIdTimeout(ev[1]), .legacyTopology(ev[10]), .stateTimeout(ev[0]),
        .portStatusChange(ev[5:3]), .resumeStart(ev[8:6]), .busResetOut(busOut),
        .shortResetActive(shortAct), .selfIdBits(sid));
    link_ctrl_model link_u (.clock(clock), .rst_n(rst_n), .sleepCmd(sleepCmd), .linkWake(wake),
        .linkPower(power), .linkRequest(req));

    always #4 clock = ~clock;

    task close_out();
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Control register view expected from its fields
    function automatic logic [9:0] ctlExp(logic rep, logic con, logic [2:0] pc, logic wat);
        return {1'b0, wat, pc, 3'h0, con, rep};
    endfunction

    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        wbReq  <= 1;
        wbWe   <= we;
        wbAdr  <= a;
        wbDatI <= d;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        if (k >= 50)
            errors++;
        rd = wbDatO;
        wbReq <= 0;
    endtask

    task automatic pulse(input logic [10:0] e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= 0;
    endtask

    task automatic evt(input logic [10:0] e, input logic [3:0] f);
        pulse(e);
        bus(0, ADDR_FLAGS, 0);
        chk("flags", rd[3:0], f);
        bus(1, ADDR_FLAGS, 32'hF);
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        close_out();
    end

    initial
    begin
        void'($urandom(26));
        p = $urandom % 3;
        pins <= 3'($urandom);
        repeat (4) @(posedge clock);
        rst_n <= 1;
        repeat (2) @(posedge clock);
        bus(0, ADDR_CONTROL, 0);
        chk("control", rd[9:0], ctlExp(1, 0, pins, 0));
        bus(0, ADDR_FLAGS, 0);
        chk("flags", rd[3:0], 4'h2);
        bus(0, 4'h2, 0);
        chk("unmapped", rd, 0);
        pins <= ~pins;
        repeat (6)
        begin
            v = $urandom & 32'h1E3;
            bus(1, ADDR_CONTROL, v);
            chk("selfid", {sid[23:20], sid[9]}, {v[7:5], v[1], v[0]});
            pulse(11'h004);
            bus(0, ADDR_CONTROL, 0);
            chk("control", rd[9:0], ctlExp(v[0], v[1], v[7:5], v[8]));
        end
        bus(1, ADDR_CONTROL, 32'h1);
        bus(1, ADDR_FLAGS, 32'h0);
        bus(0, ADDR_FLAGS, 0);
        chk("flags hold", rd[3:0], 4'h2);
        bus(1, ADDR_FLAGS, 32'h2);
        evt(11'h002, 4'h0);
        evt(11'h402, 4'h1);
        evt(11'h001, 4'h4);
        evt(11'h200, 4'h2);
        bus(1, ADDR_PORT_ENABLE, 32'(1 << p));
        evt(11'(8 << p), 4'h8);
        evt(11'(8 << ((p + 1) % 3)), 4'h0);
        evt(11'(64 << p), 4'h0);
        sleepCmd <= 1;
        pulse(11'h001);
        repeat (5) @(posedge clock);
        chk("asleep", {sid[9], oper, wake}, 0);
        bus(1, ADDR_CONTROL, 32'h101);
        n = 0;
        while (wake !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        chk("wake", wake, 1);
        sleepCmd <= 0;
        bus(1, ADDR_FLAGS, 32'hF);
        evt(11'(64 << p), 4'h8);
        bus(1, ADDR_CONTROL, 32'h201);
        n = 0;
        while (shortAct !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        chk("short start", shortAct, 1);
        bus(0, ADDR_CONTROL, 0);
        chk("request cleared", rd[9], 0);
        repeat (SHORT_RESET_CYC + 10) @(posedge clock);
        chk("short end", shortAct, 0);
        bus(1, ADDR_FLAGS, 32'hF);
        bus(1, ADDR_CONTROL, 32'h1E2);
        rst_n <= 0;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        repeat (2) @(posedge clock);
        bus(0, ADDR_CONTROL, 0);
        chk("control after reset", rd[9:0], ctlExp(1, 0, pins, 0));
        bus(0, ADDR_FLAGS, 0);
        chk("flags after reset", rd[3:0], 4'h2);
        close_out();
    end
endmodule // phy_status_bank_test
